// ### protector_pkg.sv
/*
  Constants, state codes and carrier structs for the protector configuration
  serial port. Assumes a 100 MHz core clock and a bus master that makes the
  serial clock.
*/
// How it works
// - Port is target only; it never drives the serial clock line.
// - Answer only target address 0010 000, direction bit in the byte's LSB.
// - General-call address is neither acknowledged nor acted upon.
// - Location never advances after a data byte; repeats reach the same location.
// - Last selected location is kept for later reads; a write frame sets a new one only once its location byte is received.
// - Bypass pin low: stored detection delays apply to every fault.
// - Bypass pin high: every detection delay drops to its minimum.
// - Serial port works only while the bypass pin is high.
// - Thermistor held shorted over 8 s: shorted fault, shutdown, regulator off.
// - With bypass high, 1 s of shorted thermistor is enough for shutdown.
// - No register or command enters storage mode; only the fault does.
// - In shutdown, stay asleep until a charger shows, then resume.
// - Eleven locations 0x00 to 0x0a: ten stored plus one volatile access register.
package protector_pkg;

  // bus addressing
  localparam logic [6:0] TARGET_ADDR = 7'h10;
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // register space
  localparam int NUM_REGS = 11;
  localparam logic [7:0] REG_ACCESS = 8'h00;
  localparam logic [7:0] REG_LAST = 8'h0a;
  localparam int SUPPLY_GOOD_BIT = 0;

  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int SHORT_NORMAL_MS = 8000;
  localparam int SHORT_BYPASS_MS = 1000;
  localparam int SHORT_NORMAL_CYCLES = (CLK_HZ / 1000) * SHORT_NORMAL_MS;
  localparam int SHORT_BYPASS_CYCLES = (CLK_HZ / 1000) * SHORT_BYPASS_MS;
  localparam int TIMER_W = 30;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ACK_ADDR = 4'h2,
    ST_PTR = 4'h3,
    ST_ACK_PTR = 4'h4,
    ST_WDATA = 4'h5,
    ST_ACK_W = 4'h6,
    ST_RDATA = 4'h7,
    ST_RACK = 4'h8,
    ST_IGNORE = 4'h9
  } port_state_t;

  // pin levels in the core domain
  typedef struct packed {
    logic scl;
    logic sda;
    logic bypass;
    logic ts_low;
    logic charger;
    logic supply_good;
    logic tog;
  } pins_t;

  // what the serial-clock domain hands over
  typedef struct packed {
    logic bit_val;
    logic tog;
  } link_t;

  typedef struct packed {
    pins_t s1;
    pins_t s2;
    logic scl_prev;
    logic sda_prev;
    logic tog_seen;
    port_state_t st;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic rw;
    logic [7:0] ptr;
    logic [NUM_REGS-1:1][7:0] regs;
    logic sda_oe;
    logic sda_out;
    logic [TIMER_W-1:0] timer;
    logic shutdown;
    logic short_fault;
    logic delay_minimum;
    logic regulator_enable;
  } core_t;

endpackage

// ### protector_config_serial_port.sv
/*
  Configuration serial port of the battery protector: two-wire target port,
  delay-bypass handling and the shorted-thermistor shutdown with charger wake.
  Assumes the serial data line is resolved outside from serial_data_oe, and
  that thermistor_sense_input is a comparator level, high while below the
  shorted_sensor_threshold.
*/
`timescale 1ns/1ps
module protector_config_serial_port #(
  parameter int SHORT_CYCLES_NORMAL = protector_pkg::SHORT_NORMAL_CYCLES,
  parameter int SHORT_CYCLES_BYPASS = protector_pkg::SHORT_BYPASS_CYCLES
) (
  // core clock and reset
  input wire logic clk,
  input wire logic rst,
  // two-wire link
  input wire logic serial_clock,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  // pack pins
  input wire logic delay_bypass_pin,
  input wire logic thermistor_sense_input,
  input wire logic charger_detect,
  input wire logic supply_good,
  // configuration and status
  output logic [(protector_pkg::NUM_REGS-1)*8-1:0] config_bytes,
  output logic delay_minimum,
  output logic shorted_thermistor_fault,
  output logic regulator_output_enable
);

  protector_pkg::core_t s;
  protector_pkg::core_t next_s;
  // no reset reaches this domain; its clock may stand still, so start at zero
  protector_pkg::link_t link = '0;

  // sample each bit on the serial clock rise and flag it by toggling
  always_ff @(posedge serial_clock) begin
    link.bit_val <= serial_data_in;
    link.tog <= ~link.tog;
  end

  // read path of the register space
  function automatic logic [7:0] reg_read(input protector_pkg::core_t c);
    logic [7:0] v;
    v = 8'h00;
    if (c.ptr == protector_pkg::REG_ACCESS) begin
      v[protector_pkg::SUPPLY_GOOD_BIT] = c.s2.supply_good;
    end else if (c.ptr <= protector_pkg::REG_LAST) begin
      v = c.regs[c.ptr[3:0]];
    end
    return v;
  endfunction

  // whole next state
  always_comb begin
    logic bit_ev;
    logic scl_fall;
    logic start;
    logic stop;
    logic port_en;
    logic [7:0] tx;
    logic [protector_pkg::TIMER_W-1:0] limit;
    bit_ev = 1'b0;
    scl_fall = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    port_en = 1'b0;
    tx = 8'h00;
    limit = '0;
    next_s = s;
    next_s.s1 = '{scl: serial_clock, sda: serial_data_in, bypass: delay_bypass_pin,
                  ts_low: thermistor_sense_input, charger: charger_detect,
                  supply_good: supply_good, tog: link.tog};
    next_s.s2 = s.s1;
    next_s.scl_prev = s.s2.scl;
    next_s.sda_prev = s.s2.sda;
    next_s.tog_seen = s.s2.tog;
    next_s.sda_out = 1'b0;
    // the bit value is settled long before its toggle clears the synchroniser
    bit_ev = s.s2.tog != s.tog_seen;
    scl_fall = s.scl_prev & ~s.s2.scl;
    start = s.s2.scl & s.scl_prev & s.sda_prev & ~s.s2.sda;
    stop = s.s2.scl & s.scl_prev & ~s.sda_prev & s.s2.sda;
    port_en = s.s2.bypass & ~s.shutdown;
    tx = reg_read(s);

    if (bit_ev) begin
      next_s.shift = {s.shift[6:0], link.bit_val};
      next_s.cnt = 4'(s.cnt + 4'h1);
    end

    // byte engine; the data line only changes after a clock fall
    unique case (s.st)
      protector_pkg::ST_IDLE, protector_pkg::ST_IGNORE: begin
        next_s.sda_oe = 1'b0;
      end
      protector_pkg::ST_ADDR: begin
        if (scl_fall && s.cnt == protector_pkg::BITS_PER_BYTE) begin
          if (s.shift[7:1] == protector_pkg::TARGET_ADDR && port_en) begin
            next_s.rw = s.shift[0];
            next_s.sda_oe = 1'b1;
            next_s.st = protector_pkg::ST_ACK_ADDR;
          end else begin
            // general call and foreign addresses fall here
            next_s.st = protector_pkg::ST_IGNORE;
          end
        end
      end
      protector_pkg::ST_ACK_ADDR: begin
        if (scl_fall) begin
          next_s.cnt = 4'h0;
          if (s.rw) begin
            // read from the kept location, no new location needed
            next_s.sda_oe = ~tx[7];
            next_s.st = protector_pkg::ST_RDATA;
          end else begin
            next_s.sda_oe = 1'b0;
            next_s.st = protector_pkg::ST_PTR;
          end
        end
      end
      protector_pkg::ST_PTR: begin
        if (scl_fall && s.cnt == protector_pkg::BITS_PER_BYTE) begin
          next_s.ptr = s.shift;
          next_s.sda_oe = 1'b1;
          next_s.st = protector_pkg::ST_ACK_PTR;
        end
      end
      protector_pkg::ST_ACK_PTR, protector_pkg::ST_ACK_W: begin
        if (scl_fall) begin
          next_s.cnt = 4'h0;
          next_s.sda_oe = 1'b0;
          next_s.st = protector_pkg::ST_WDATA;
        end
      end
      protector_pkg::ST_WDATA: begin
        if (scl_fall && s.cnt == protector_pkg::BITS_PER_BYTE) begin
          // location 0x00 holds only a status bit; nothing here starts storage
          if (s.ptr != protector_pkg::REG_ACCESS && s.ptr <= protector_pkg::REG_LAST) begin
            next_s.regs[s.ptr[3:0]] = s.shift;
          end
          next_s.sda_oe = 1'b1; // pointer stays put for the next byte
          next_s.st = protector_pkg::ST_ACK_W;
        end
      end
      protector_pkg::ST_RDATA: begin
        if (scl_fall) begin
          if (s.cnt == protector_pkg::BITS_PER_BYTE) begin
            next_s.sda_oe = 1'b0;
            next_s.st = protector_pkg::ST_RACK;
          end else begin
            next_s.sda_oe = ~tx[~s.cnt[2:0]];
          end
        end
      end
      protector_pkg::ST_RACK: begin
        // master ack repeats the same location, nack ends the read
        if (bit_ev) begin
          next_s.st = link.bit_val ? protector_pkg::ST_IGNORE : protector_pkg::ST_ACK_ADDR;
        end
      end
      default: begin
        next_s.st = protector_pkg::ST_IDLE;
      end
    endcase

    // start and stop override the byte engine
    if (start) begin
      next_s.st = protector_pkg::ST_ADDR;
      next_s.cnt = 4'h0;
      next_s.sda_oe = 1'b0;
    end else if (stop) begin
      next_s.st = protector_pkg::ST_IDLE;
      next_s.sda_oe = 1'b0;
    end

    // delay selection follows the bypass pin
    next_s.delay_minimum = s.s2.bypass;
    limit = s.s2.bypass ? protector_pkg::TIMER_W'(SHORT_CYCLES_BYPASS)
                        : protector_pkg::TIMER_W'(SHORT_CYCLES_NORMAL);

    // shorted-thermistor timer and charger wake
    if (s.shutdown) begin
      next_s.timer = '0;
      if (s.s2.charger) begin
        next_s.shutdown = 1'b0;
        next_s.short_fault = 1'b0;
        next_s.regulator_enable = 1'b1;
      end
    end else if (s.s2.ts_low) begin
      if (s.timer >= limit) begin
        next_s.shutdown = 1'b1;
        next_s.short_fault = 1'b1;
        next_s.regulator_enable = 1'b0;
        next_s.timer = '0;
      end else begin
        next_s.timer = protector_pkg::TIMER_W'(s.timer + 1'b1);
      end
    end else begin
      next_s.timer = '0; // a glitch-free stretch is needed, so any release restarts
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.regulator_enable <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state
  assign serial_data_out = s.sda_out;
  assign serial_data_oe = s.sda_oe;
  assign config_bytes = s.regs;
  assign delay_minimum = s.delay_minimum;
  assign shorted_thermistor_fault = s.short_fault;
  assign regulator_output_enable = s.regulator_enable;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence addr_byte_done;
    s.st == protector_pkg::ST_ADDR && s.scl_prev && !s.s2.scl &&
      s.cnt == protector_pkg::BITS_PER_BYTE;
  endsequence

  AST_ACK_ONLY_OWN_ADDR: assert property (
    addr_byte_done ##1 s.st == protector_pkg::ST_ACK_ADDR |->
      $past(s.shift[7:1]) == protector_pkg::TARGET_ADDR && s.sda_oe)
    else $error("acknowledged an address other than the target");

  AST_GENERAL_CALL_IGNORED: assert property (
    addr_byte_done and s.shift[7:1] == protector_pkg::GENERAL_CALL_ADDR |=>
      s.st == protector_pkg::ST_IGNORE ##1 !s.sda_oe)
    else $error("general call was not ignored");

  AST_PORT_NEEDS_BYPASS: assert property (
    addr_byte_done and !s.s2.bypass |=> s.st != protector_pkg::ST_ACK_ADDR && !s.sda_oe)
    else $error("port answered with bypass pin low");

  AST_IGNORE_RELEASED: assert property (
    s.st == protector_pkg::ST_IGNORE |-> !s.sda_oe && !serial_data_out)
    else $error("data line driven in an ignored transfer");

  AST_PTR_ONLY_FROM_PTR_BYTE: assert property (
    $changed(s.ptr) |-> $past(s.st) == protector_pkg::ST_PTR)
    else $error("location moved outside a location byte");

  AST_PTR_KEPT_OVER_START: assert property (
    s.st == protector_pkg::ST_IDLE ##1 s.st == protector_pkg::ST_ADDR |-> $stable(s.ptr))
    else $error("location lost across transfers");

  AST_DELAY_FOLLOWS_PIN: assert property (
    s.s2.bypass |=> delay_minimum ##1 $past(s.s2.bypass, 2) == $past(delay_minimum))
    else $error("delay selection does not follow the bypass pin");

  AST_SHORT_SHUTDOWN: assert property (
    !s.shutdown && s.s2.ts_low && s.timer >= (s.s2.bypass ?
      protector_pkg::TIMER_W'(SHORT_CYCLES_BYPASS) : protector_pkg::TIMER_W'(SHORT_CYCLES_NORMAL))
      |=> s.shutdown && shorted_thermistor_fault && !regulator_output_enable)
    else $error("shorted thermistor did not shut down");

  AST_NO_EARLY_SHUTDOWN: assert property (
    $rose(s.shutdown) |-> $past(s.s2.ts_low) && $past(s.timer) != '0)
    else $error("shutdown without a shorted thermistor");

  AST_CHARGER_WAKE: assert property (
    s.shutdown && s.s2.charger |=> !s.shutdown && regulator_output_enable ##1 !s.shutdown)
    else $error("charger did not wake the device");

endmodule

// ### serial_master_model.sv
/*
  Behavioural bus master for the protector port: frames, bytes, acks.
  Assumes an open-drain data line with a pull-up resolved by the bench.
*/
`timescale 1ns/1ps
module serial_master_model (
  // two-wire bus side
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  logic base = 1'b0;
  int span = 12;
  // 6 ns base, free of core clock phase
  always #3 base = ~base;
  // bus idles high between frames; clock stands still
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // one bus phase; span stays above six core cycles
  task automatic ph();
    repeat (span) @(posedge base);
  endtask
  // data moves only with clock high at start and stop
  task automatic start();
    sda_low = 1'b1;
    ph();
    scl = 1'b0;
    ph();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    sda_low = 1'b0;
    ph();
  endtask
  // one bit: drive while low, sample on the high phase
  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    ph();
    scl = 1'b1;
    ph();
    r = sda;
    scl = 1'b0;
    ph();
  endtask
  // eight bits msb first, then the ninth; m is our own ack level
  task automatic byte_io(input logic [7:0] d, input logic m, output logic [7:0] q,
      output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(m, a);
  endtask
endmodule

// ### protector_config_serial_port_tb.sv
/*
  Self-checking bench of the protector configuration port.
  Assumes shortened shutdown limits and the master model beside it.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module protector_config_serial_port_tb;
  localparam int NRM = 200;
  localparam int BYP = 50;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic bypass = 1'b1;
  logic ts = 1'b0;
  logic chg = 1'b0;
  logic sg = 1'b1;
  logic scl, sda_low, oe, dout, dmin, fault, reg_en, a0, a1, a2;
  logic [(protector_pkg::NUM_REGS-1)*8-1:0] cfg;
  logic [7:0] q;
  int miscompares = 0;
  int comparisons = 0;
  // pull-up wins unless someone pulls low
  wire sda = ~(sda_low | (oe & ~dout));
  always #5 clk = ~clk;
  protector_config_serial_port #(.SHORT_CYCLES_NORMAL(NRM), .SHORT_CYCLES_BYPASS(BYP)) dut_u (
    .clk(clk), .rst(rst), .serial_clock(scl), .serial_data_in(sda),
    .serial_data_out(dout), .serial_data_oe(oe), .delay_bypass_pin(bypass),
    .thermistor_sense_input(ts), .charger_detect(chg), .supply_good(sg),
    .config_bytes(cfg), .delay_minimum(dmin), .shorted_thermistor_fault(fault),
    .regulator_output_enable(reg_en));
  serial_master_model m_u (.scl(scl), .sda_low(sda_low), .sda(sda));
  task automatic print_verdict();
    if (miscompares == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // pin change, then let the synchronisers settle
  task automatic pins(input logic b, input logic t, input logic c);
    @(negedge clk);
    bypass = b;
    ts = t;
    chg = c;
    repeat (6) @(negedge clk);
  endtask
  task automatic t_reset();
    `CHK(cfg, 80'h0)
    `CHK({fault, reg_en, oe}, 3'h2)
    `CHK(dout, 1'b0)
  endtask
  // two data bytes in one frame must land on the same location
  task automatic t_write();
    pins(1'b1, 1'b0, 1'b0);
    `CHK(dmin, 1'b1)
    m_u.start();
    m_u.byte_io(8'h20, 1'b1, q, a0);
    m_u.byte_io(8'h03, 1'b1, q, a1);
    m_u.byte_io(8'h5a, 1'b1, q, a2);
    m_u.byte_io(8'ha5, 1'b1, q, a2);
    m_u.stop();
    `CHK({a0, a1, a2}, 3'h0)
    `CHK(cfg[23:16], 8'ha5)
    `CHK(cfg[31:24], 8'h00)
  endtask
  // slow master; no location sent, repeat read stays put
  task automatic t_read();
    m_u.span = 30;
    m_u.start();
    m_u.byte_io(8'h21, 1'b1, q, a0);
    `CHK(a0, 1'b0)
    m_u.byte_io(8'hff, 1'b0, q, a1);
    `CHK(q, 8'ha5)
    m_u.byte_io(8'hff, 1'b1, q, a1);
    `CHK(q, 8'ha5)
    m_u.stop();
    // access location: only the supply status bit reads back
    m_u.start();
    m_u.byte_io(8'h20, 1'b1, q, a0);
    m_u.byte_io(8'h00, 1'b1, q, a1);
    m_u.stop();
    m_u.start();
    m_u.byte_io(8'h21, 1'b1, q, a2);
    m_u.byte_io(8'hff, 1'b1, q, a1);
    m_u.stop();
    `CHK(q, 8'h01)
    `CHK({a0, a2}, 2'h0)
    m_u.span = 12;
  endtask
  // refused frame: no ack on any byte, nothing stored
  task automatic t_refuse(input logic [7:0] ad);
    m_u.start();
    m_u.byte_io(ad, 1'b1, q, a0);
    m_u.byte_io(8'h03, 1'b1, q, a1);
    m_u.byte_io(8'h11, 1'b1, q, a2);
    m_u.stop();
    `CHK({a0, a1, a2}, 3'h7)
    `CHK(cfg[23:16], 8'ha5)
  endtask
  // shorted thermistor: quiet until the limit, then shutdown until charger
  task automatic t_short(input logic b, input int lim);
    pins(b, 1'b0, 1'b0);
    `CHK(dmin, b)
    @(negedge clk);
    ts = 1'b1;
    repeat (lim - 6) @(negedge clk);
    `CHK(fault, 1'b0)
    repeat (14) @(negedge clk);
    `CHK({fault, reg_en}, 2'h2)
    pins(b, 1'b0, 1'b0);
    `CHK({fault, reg_en}, 2'h2)
    pins(b, 1'b0, 1'b1);
    `CHK({fault, reg_en}, 2'h1)
    pins(b, 1'b0, 1'b0);
  endtask
  // hang guard, far beyond the expected run
  initial begin
    #500us;
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_reset();
    t_write();
    t_read();
    t_refuse(8'h00);
    t_refuse(8'h22);
    pins(1'b0, 1'b0, 1'b0);
    t_refuse(8'h20);
    t_short(1'b0, NRM);
    t_short(1'b1, BYP);
    print_verdict();
  end
endmodule
